//--- common/supervisor_defines.svh
// Purpose: Timing constants for the reset supervisor
// Assumes: 10 MHz clk, 100 ns period
// Notes: Hold and watchdog counts are defaults only; top parameters override them; MAN_FILTER_CYC is fixed
`ifndef SUPERVISOR_DEFINES_SVH
`define SUPERVISOR_DEFINES_SVH
`define CLK_PERIOD_NS 100
`define RESET_HOLD_US 140000
`define RESET_HOLD_CYC ((`RESET_HOLD_US * 1000) / `CLK_PERIOD_NS)
`define WATCHDOG_US 1600000
`define WATCHDOG_CYC ((`WATCHDOG_US * 1000) / `CLK_PERIOD_NS)
`define MAN_GLITCH_NS 100
`define MAN_FILTER_CYC ((`MAN_GLITCH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS + 1)
`define CNT_W 32
`endif

//--- common/supervisor_pkg.sv
// Purpose: Types for the reset supervisor
// Assumes: Nothing
// Notes: Two-state reset sequencer
package supervisor_pkg;
  typedef enum logic [0:0] {
    ST_RUN = 1'b0,
    ST_HOLD = 1'b1
  } sup_state_t;
endpackage

//--- design/input_sync.sv
// Purpose: Two-flop synchroniser for one pin
// Assumes: Single clk domain
// Notes: Output is the second flop only
`timescale 1ns/1ps
`default_nettype none
module input_sync (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic rst_val,
  input wire logic pin_in,
  output logic sync_out
);
  logic meta_r;
  always_ff @(posedge clk) begin
    // Reset to rst_val: the pin's idle level, except the supply instance, which starts as a low-supply request
    if (sys_rst) begin
      meta_r <= rst_val;
      sync_out <= rst_val;
    end else begin
      meta_r <= pin_in;
      sync_out <= meta_r;
    end
  end
endmodule // input_sync
`default_nettype wire

//--- design/supervisor_reset_watchdog.sv
// Purpose: Reset supervisor: supply, manual reset and watchdog to one reset
// Assumes: Comparator gives supply_low; watchdog pin driven or floated
// Notes: Watchdog floating is seen through wdog_drive_en from pad sensing
`timescale 1ns/1ps
`default_nettype none
`include "supervisor_defines.svh"
module supervisor_reset_watchdog
  import supervisor_pkg::*;
#(
  parameter logic [`CNT_W-1:0] HOLD_CYC = `RESET_HOLD_CYC,
  parameter logic [`CNT_W-1:0] WDOG_CYC = `WATCHDOG_CYC
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic supply_low,
  input wire logic manual_reset_n,
  input wire logic watchdog_toggle_in,
  input wire logic wdog_drive_en,
  output logic reset_out_n,
  output logic reset_out,
  output logic reset_od_out,
  output logic reset_od_oe
);
  // ***************************************************************
  // Input synchronisers
  // ***************************************************************
  logic supply_low_s, man_rst_n_s, wdog_s, wdog_en_s;
  // Supply flop starts as low supply, so reset holds through start-up
  input_sync u_sync_supply (
    .clk(clk), .sys_rst(sys_rst), .rst_val(1'b1),
    .pin_in(supply_low), .sync_out(supply_low_s));
  input_sync u_sync_man (
    .clk(clk), .sys_rst(sys_rst), .rst_val(1'b1),
    .pin_in(manual_reset_n), .sync_out(man_rst_n_s));
  input_sync u_sync_wdog (
    .clk(clk), .sys_rst(sys_rst), .rst_val(1'b0),
    .pin_in(watchdog_toggle_in), .sync_out(wdog_s));
  input_sync u_sync_wden (
    .clk(clk), .sys_rst(sys_rst), .rst_val(1'b0),
    .pin_in(wdog_drive_en), .sync_out(wdog_en_s));

  // ***************************************************************
  // Manual reset glitch filter
  // ***************************************************************
  // Low must persist past the glitch width before it counts
  logic [3:0] man_low_cnt_r;
  logic man_req_r;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      man_low_cnt_r <= 4'h0;
      man_req_r <= 1'b0;
    end else if (man_rst_n_s) begin
      man_low_cnt_r <= 4'h0;
      man_req_r <= 1'b0;
    end else if (man_low_cnt_r >= 4'(`MAN_FILTER_CYC)) begin
      man_req_r <= 1'b1;
    end else begin
      man_low_cnt_r <= man_low_cnt_r + 4'h1;
    end
  end

  // ***************************************************************
  // Watchdog
  // ***************************************************************
  // Edge seen on synchronised level; a 50 ns pulse needs the pad latch
  // upstream, since it is shorter than one clock
  logic wdog_d_r, wdog_edge;
  logic [`CNT_W-1:0] wd_cnt_r;
  logic wd_expire_r;
  logic in_reset;
  always_ff @(posedge clk) begin
    if (sys_rst) wdog_d_r <= 1'b0;
    else wdog_d_r <= wdog_s;
  end
  assign wdog_edge = wdog_s ^ wdog_d_r;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wd_cnt_r <= '0;
      wd_expire_r <= 1'b0;
    end else if (in_reset || wdog_edge || !wdog_en_s) begin
      wd_cnt_r <= '0;
      wd_expire_r <= 1'b0;
    end else if (wd_cnt_r >= WDOG_CYC - 1) begin
      wd_cnt_r <= '0;
      wd_expire_r <= 1'b1;
    end else begin
      wd_cnt_r <= wd_cnt_r + 1'b1;
      wd_expire_r <= 1'b0;
    end
  end

  // ***************************************************************
  // Reset sequencer
  // ***************************************************************
  sup_state_t state_r;
  logic [`CNT_W-1:0] hold_cnt_r;
  logic src_active;
  assign src_active = supply_low_s || man_req_r || wd_expire_r;
  assign in_reset = (state_r == ST_HOLD);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_r <= ST_HOLD;
      hold_cnt_r <= '0;
    end else begin
      case (state_r)
        ST_RUN: begin
          hold_cnt_r <= '0;
          if (src_active) state_r <= ST_HOLD;
        end
        ST_HOLD: begin
          if (src_active) begin
            hold_cnt_r <= '0;
          end else if (hold_cnt_r >= HOLD_CYC - 1) begin
            state_r <= ST_RUN;
            hold_cnt_r <= '0;
          end else begin
            hold_cnt_r <= hold_cnt_r + 1'b1;
          end
        end
        default: state_r <= ST_HOLD;
      endcase
    end
  end

  // ***************************************************************
  // Outputs
  // ***************************************************************
  logic rst_nxt;
  assign rst_nxt = (state_r == ST_HOLD) ? !(hold_cnt_r >= HOLD_CYC - 1 && !src_active)
                                        : src_active;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reset_out_n <= 1'b0;
      reset_out <= 1'b1;
      reset_od_out <= 1'b0;
      reset_od_oe <= 1'b1;
    end else begin
      reset_out_n <= !rst_nxt;
      reset_out <= rst_nxt;
      reset_od_out <= 1'b0;
      reset_od_oe <= rst_nxt;
    end
  end

  // ***************************************************************
  // Assertions
  // ***************************************************************
  sequence s_hold_done;
    in_reset && !src_active && hold_cnt_r >= HOLD_CYC - 1;
  endsequence
  a_out_complement: assert property (@(posedge clk) disable iff (sys_rst)
    reset_out == !reset_out_n) else $error("outputs not complementary");
  a_od_low_only: assert property (@(posedge clk) disable iff (sys_rst)
    reset_od_oe == !reset_out_n && reset_od_out == 1'b0)
    else $error("open drain misdriven");
  a_supply_reset: assert property (@(posedge clk) disable iff (sys_rst)
    supply_low_s |=> !reset_out_n) else $error("supply low no reset");
  a_mr_reset: assert property (@(posedge clk) disable iff (sys_rst)
    man_req_r |=> !reset_out_n) else $error("manual reset ignored");
  a_hold_stretch: assert property (@(posedge clk) disable iff (sys_rst)
    in_reset && src_active |=> in_reset && hold_cnt_r == '0)
    else $error("hold not restarted");
  a_release_time: assert property (@(posedge clk) disable iff (sys_rst)
    s_hold_done |=> !in_reset ##0 reset_out_n) else $error("release late");
  a_wd_zero_reset: assert property (@(posedge clk) disable iff (sys_rst)
    in_reset |=> wd_cnt_r == '0) else $error("watchdog ran in reset");
  a_wd_edge_clear: assert property (@(posedge clk) disable iff (sys_rst)
    wdog_edge |=> wd_cnt_r == '0) else $error("edge did not clear");
  a_wd_disabled: assert property (@(posedge clk) disable iff (sys_rst)
    !wdog_en_s |=> !wd_expire_r) else $error("disabled watchdog fired");
  a_wd_expire: assert property (@(posedge clk) disable iff (sys_rst)
    !in_reset && wdog_en_s && !wdog_edge && wd_cnt_r == WDOG_CYC - 1 |=> wd_expire_r)
    else $error("watchdog did not expire");
  a_wd_restart: assert property (@(posedge clk) disable iff (sys_rst)
    s_hold_done |=> wd_cnt_r == '0) else $error("watchdog not from zero");
endmodule // supervisor_reset_watchdog
`default_nettype wire

//--- testbench/cpu_partner.sv
// Purpose: Processor model that services the watchdog pin
// Assumes: Moves its pins 10 ns after the clock rises
// Notes: A released pin flips once, so a stale level is never seen
`timescale 1ns/1ps
`default_nettype none
module cpu_partner #(
  parameter int MAX_GAP = 'h14
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic drive,
  output logic wdog_pin,
  output logic wdog_pin_en
);
  int gap = 4;
  initial begin
    wdog_pin = 1'b0;
    wdog_pin_en = 1'b1;
  end
  always @(posedge clk) begin
    wdog_pin_en <= #10 drive;
    if (!drive && wdog_pin_en) begin
      wdog_pin <= #10 ~wdog_pin;
    end else if (drive && run && rst_n) begin
      gap = gap - 1;
      if (gap == 0) begin
        wdog_pin <= #10 ~wdog_pin;
        gap = 2 + $urandom % MAX_GAP;
      end
    end
  end
endmodule // cpu_partner
`default_nettype wire

//--- testbench/supervisor_reset_watchdog_tb.sv
// Purpose: Self-checking bench for the reset supervisor
// Assumes: Short hold and watchdog counts
// Notes: Latency windows allow for input synchronisers
`timescale 1ns/1ps
`default_nettype none
module supervisor_reset_watchdog_tb;
  localparam int HOLD = 'h14;
  localparam int WDOG = 'h32;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic supply_low = 1'b0;
  logic manual_reset_n = 1'b1;
  logic run = 1'b0;
  logic drive = 1'b1;
  logic wdog_pin, wdog_pin_en, reset_out_n, reset_out, reset_od_out, reset_od_oe;
  int fails = 0;
  int tests_run = 0;
  int cyc = 0;
  int last_edge = 0;
  always #50 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  always @(wdog_pin) last_edge = cyc;
  supervisor_reset_watchdog #(.HOLD_CYC(HOLD), .WDOG_CYC(WDOG)) i_supervisor_reset_watchdog (
    .clk(clk), .sys_rst(sys_rst), .supply_low(supply_low), .manual_reset_n(manual_reset_n),
    .watchdog_toggle_in(wdog_pin), .wdog_drive_en(wdog_pin_en), .reset_out_n(reset_out_n),
    .reset_out(reset_out), .reset_od_out(reset_od_out), .reset_od_oe(reset_od_oe));
  cpu_partner #(.MAX_GAP('h14)) i_cpu_partner (.clk(clk), .rst_n(reset_out_n), .run(run),
    .drive(drive), .wdog_pin(wdog_pin), .wdog_pin_en(wdog_pin_en));
  // ****************
  // Tasks
  // ****************
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
    #10;
  endtask
  task automatic flag(input logic [31:0] e, input logic [31:0] g);
    fails++;
    $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
  endtask
  task automatic check_rst(input logic exp);
    tests_run++;
    if (reset_out_n !== ~exp || reset_out !== exp || reset_od_oe !== exp || reset_od_out !== 1'b0)
      flag({exp, ~exp, exp, 1'b0}, {reset_out, reset_out_n, reset_od_oe, reset_od_out});
  endtask
  // Span counts the hold cycles still owed when called
  task automatic check_hold(input int span);
    int n;
    repeat (span) begin
      wait_cyc(1);
      check_rst(1'b1);
    end
    n = 0;
    while (reset_out_n !== 1'b1 && n < 12) begin
      wait_cyc(1);
      n++;
    end
    check_rst(1'b0);
  endtask
  task automatic wdog_expire();
    int n;
    n = 0;
    while (reset_out_n === 1'b1 && n < 3 * WDOG) begin
      wait_cyc(1);
      n++;
    end
    n = cyc - last_edge;
    tests_run++;
    if (n < WDOG || n > WDOG + 8) flag(WDOG, n);
  endtask
  task automatic give_verdict();
    $display("fails=%0d tests_run=%0d", fails, tests_run);
    if (fails == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // ****************
  // Sequence
  // ****************
  initial begin
    void'($urandom(3));
    wait_cyc(10);
    check_rst(1'b1);
    sys_rst = 1'b0;
    check_hold(HOLD);
    supply_low = 1'b1;
    wait_cyc(6);
    check_rst(1'b1);
    wait_cyc(10 + $urandom % 20);
    supply_low = 1'b0;
    check_hold(HOLD);
    manual_reset_n = 1'b0;
    wait_cyc(1);
    manual_reset_n = 1'b1;
    repeat (10) begin
      wait_cyc(1);
      check_rst(1'b0);
    end
    manual_reset_n = 1'b0;
    wait_cyc(10 + $urandom % 20);
    check_rst(1'b1);
    manual_reset_n = 1'b1;
    check_hold(HOLD);
    run = 1'b1;
    repeat (8 * WDOG) begin
      wait_cyc(1);
      check_rst(1'b0);
    end
    run = 1'b0;
    // Watchdog reset is already one cycle old when it is seen
    wdog_expire();
    check_hold(HOLD - 1);
    last_edge = cyc;
    wdog_expire();
    check_hold(HOLD - 1);
    drive = 1'b0;
    repeat (3 * WDOG) begin
      wait_cyc(1);
      check_rst(1'b0);
    end
    give_verdict();
  end
  initial begin
    #1000000;
    fails++;
    give_verdict();
  end
endmodule // supervisor_reset_watchdog_tb
`default_nettype wire
